//--- rtl/scp_apb.sv
`default_nettype none
// APB slave holding the controller's own registers.
module scp_apb (
    input  wire logic        clk_in,      // System clock.
    input  wire logic        rst_in,      // Asynchronous reset.
    input  wire logic        psel,        // APB select.
    input  wire logic        penable,     // APB enable.
    input  wire logic        pwrite,      // APB direction.
    input  wire logic [7:0]  paddr,       // APB byte address.
    input  wire logic [31:0] pwdata,      // APB write data.
    output logic [31:0]      prdata,      // APB read data.
    output logic             pready,      // APB ready.
    output logic             pslverr,     // APB error.
    input  wire logic        busy_in,     // Engine busy.
    input  wire logic        done_in,     // Engine finished a command.
    input  wire logic        rdm_in,      // Readback mode believed on.
    input  wire logic [15:0] rdata_in,    // Last readback word.
    output scp_pkg::scp_cmd_t cmd_out,    // Command to launch.
    output logic             go_out       // Launch pulse.
);
    logic done_q;
    logic acc;

    assign acc     = psel && penable;
    assign pready  = 1'b1;
    assign pslverr = acc && !(paddr == scp_pkg::REG_CTRL || paddr == scp_pkg::REG_FRAME
                     || paddr == scp_pkg::REG_STATUS || paddr == scp_pkg::REG_RDATA);

    // Frame register and launch strobe; a launch while busy is dropped.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cmd_out <= '0;
            go_out  <= 1'b0;
        end else begin
            go_out <= 1'b0;
            if (acc && pwrite && paddr == scp_pkg::REG_FRAME) begin
                cmd_out.frame <= pwdata[23:0];
            end
            if (acc && pwrite && paddr == scp_pkg::REG_CTRL && !busy_in) begin
                cmd_out.read  <= pwdata[scp_pkg::CTRL_READ];
                cmd_out.hwrst <= pwdata[scp_pkg::CTRL_HWRST];
                go_out        <= pwdata[scp_pkg::CTRL_GO];
            end
        end
    end

    // Sticky done flag; a new completion wins over the clear on read.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            done_q <= 1'b0;
        end else if (done_in) begin
            done_q <= 1'b1;
        end else if (acc && !pwrite && paddr == scp_pkg::REG_STATUS) begin
            done_q <= 1'b0;
        end
    end

    // Read data multiplexer.
    always_comb begin
        prdata = 32'h0000_0000;
        if (acc && !pwrite) begin
            unique case (paddr)
                scp_pkg::REG_FRAME:  prdata = {8'h00, cmd_out.frame};
                scp_pkg::REG_STATUS: prdata = {29'h0, rdm_in, done_q, busy_in};
                scp_pkg::REG_RDATA:  prdata = {16'h0000, rdata_in};
                default:             prdata = 32'h0000_0000;
            endcase
        end
    end
endmodule : scp_apb
`default_nettype wire

//--- rtl/scp_ctrl.sv
// The implementer's own choices: the APB register port and the address map.
`default_nettype none
module scp_ctrl (
    input  wire logic        clk_in,                 // System clock, 100 MHz.
    input  wire logic        rst_in,                 // Asynchronous reset, active high.
    input  wire logic        psel,                   // APB select.
    input  wire logic        penable,                // APB enable.
    input  wire logic        pwrite,                 // APB direction.
    input  wire logic [7:0]  paddr,                  // APB byte address.
    input  wire logic [31:0] pwdata,                 // APB write data.
    output logic [31:0]      prdata,                 // APB read data.
    output logic             pready,                 // APB ready.
    output logic             pslverr,                // APB error.
    output logic             sel_n_out,              // Device select, active low.
    output logic             sclk_out,               // Device shift clock.
    output logic             serial_in_line_out,     // Serial data to device.
    output logic             dev_reset_out,          // Device hardware reset, active high.
    input  wire logic        serial_readback_line_in // Readback bit from device.
);
    // ***********************************************************
    // States of the frame engine.
    // ***********************************************************
    typedef enum logic [5:0] {
        ST_IDLE  = 6'b000001,
        ST_RST   = 6'b000010,
        ST_RWAIT = 6'b000100,
        ST_SETUP = 6'b001000,
        ST_LOW   = 6'b010000,
        ST_HIGH  = 6'b100000
    } scp_state_t;

    scp_state_t         state_q;
    scp_pkg::scp_cmd_t  cmd;
    scp_pkg::scp_pins_t pins_q;
    logic               go;
    logic               done_q;
    logic               rdm_q;
    logic [23:0]        shift_q;
    logic [4:0]         bit_q;
    logic [7:0]         tmr_q;
    logic [15:0]        rdata_q;
    logic               rb_sync;
    logic [3:0]         gap_q;

    // Cycle count per phase; the reset wait must fit the timer and a half period must be at least one cycle.
    if (scp_pkg::HALF_CYC < 1 || scp_pkg::RST_WAIT_CYC > 255) begin : g_bad_timing
        $error("scp_ctrl: timing constants out of range");
    end

    // Timer load function used by every phase.
    function automatic logic [7:0] cyc(input int unsigned n);
        cyc = 8'((n > 0) ? n - 1 : 0);
    endfunction : cyc

    scp_apb u_apb (
        .clk_in   (clk_in),
        .rst_in   (rst_in),
        .psel     (psel),
        .penable  (penable),
        .pwrite   (pwrite),
        .paddr    (paddr),
        .pwdata   (pwdata),
        .prdata   (prdata),
        .pready   (pready),
        .pslverr  (pslverr),
        .busy_in  (state_q != ST_IDLE),
        .done_in  (done_q),
        .rdm_in   (rdm_q),
        .rdata_in (rdata_q),
        .cmd_out  (cmd),
        .go_out   (go)
    );

    scp_sync u_rb_sync (
        .clk_in (clk_in),
        .rst_in (rst_in),
        .d_in   (serial_readback_line_in),
        .q_out  (rb_sync)
    );

    assign sel_n_out          = pins_q.sel_n;
    assign sclk_out           = pins_q.sclk;
    assign serial_in_line_out = pins_q.serial_in_line;
    assign dev_reset_out      = pins_q.reset;

    // ***********************************************************
    // Frame engine: reset pulse, select, 24 clocked bits, release.
    // ***********************************************************
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q <= ST_IDLE;
            pins_q  <= '{sel_n: 1'b1, sclk: 1'b0, serial_in_line: 1'b0, reset: 1'b0};
            shift_q <= 24'h00_0000;
            bit_q   <= 5'h00;
            tmr_q   <= 8'h00;
            done_q  <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (tmr_q != 8'h00) begin
                tmr_q <= tmr_q - 8'h01;
            end else begin
                unique case (state_q)
                    ST_IDLE: begin
                        if (go && cmd.hwrst) begin
                            pins_q.reset <= 1'b1;
                            tmr_q        <= cyc(scp_pkg::RST_PULSE_CYC);
                            state_q      <= ST_RST;
                        end else if (go) begin
                            shift_q      <= cmd.frame;
                            bit_q        <= 5'h00;
                            pins_q.sel_n <= 1'b0;
                            tmr_q        <= cyc(scp_pkg::SETUP_CYC);
                            state_q      <= ST_SETUP;
                        end
                    end
                    ST_RST: begin
                        pins_q.reset <= 1'b0;
                        tmr_q        <= cyc(scp_pkg::RST_WAIT_CYC);
                        state_q      <= ST_RWAIT;
                    end
                    ST_RWAIT: begin
                        done_q  <= 1'b1;
                        state_q <= ST_IDLE;
                    end
                    ST_SETUP: begin
                        // Present the next bit while the clock is low.
                        pins_q.serial_in_line <= shift_q[23];
                        tmr_q        <= cyc(scp_pkg::HALF_CYC);
                        state_q      <= ST_LOW;
                    end
                    ST_LOW: begin
                        pins_q.sclk <= 1'b1;
                        shift_q     <= {shift_q[22:0], 1'b0};
                        bit_q       <= bit_q + 5'h01;
                        tmr_q       <= cyc(scp_pkg::HALF_CYC);
                        state_q     <= ST_HIGH;
                    end
                    ST_HIGH: begin
                        pins_q.sclk <= 1'b0;
                        if (bit_q == 5'(scp_pkg::FRAME_BITS)) begin
                            // Whole frame sent, never a partial one.
                            pins_q.sel_n <= 1'b1;
                            tmr_q        <= cyc(scp_pkg::SETUP_CYC);
                            done_q       <= 1'b1;
                            state_q      <= ST_IDLE;
                        end else begin
                            pins_q.serial_in_line <= shift_q[23];
                            tmr_q        <= cyc(scp_pkg::HALF_CYC);
                            state_q      <= ST_LOW;
                        end
                    end
                    default: state_q <= ST_IDLE;
                endcase
            end
        end
    end

    // Readback capture on the controller's rising shift clock, data bits only.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_q <= 16'h0000;
        end else if (state_q == ST_LOW && tmr_q == 8'h00 && cmd.read
                     && bit_q >= 5'(scp_pkg::ADDR_BITS)) begin
            rdata_q <= {rdata_q[14:0], rb_sync};
        end
    end

    // Tracks readback mode from frames written to address 1.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdm_q <= 1'b0;
        end else if (state_q == ST_RWAIT) begin
            rdm_q <= 1'b0;
        end else if (go && !cmd.hwrst && cmd.frame[23:16] == scp_pkg::READOUT_ADDR) begin
            rdm_q <= cmd.frame[scp_pkg::READOUT_BIT];
        end else if (go && !cmd.hwrst && !rdm_q && cmd.frame[23:16] == scp_pkg::SWRST_ADDR
                     && cmd.frame[15:0] == scp_pkg::SWRST_DATA) begin
            rdm_q <= 1'b0;
        end
    end

    // Counts cycles since the device reset pin went low, saturating at its top.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            gap_q <= 4'hf;
        end else if (pins_q.reset) begin
            gap_q <= 4'h0;
        end else if (gap_q != 4'hf) begin
            gap_q <= gap_q + 4'h1;
        end
    end

    // ***********************************************************
    // Assertions.
    // ***********************************************************
    a_sclk_idle_low: assert property (@(posedge clk_in) disable iff (rst_in)
        pins_q.sel_n |-> !pins_q.sclk) else $error("sclk high while deselected");
    a_frame_len: assert property (@(posedge clk_in) disable iff (rst_in)
        $rose(pins_q.sel_n) |-> bit_q == 5'd24) else $error("frame not 24 bits");
    a_rst_width: assert property (@(posedge clk_in) disable iff (rst_in)
        $rose(pins_q.reset) |-> pins_q.reset [*5]) else $error("reset pulse short");
    a_rst_gap: assert property (@(posedge clk_in) disable iff (rst_in)
        !pins_q.sel_n |-> gap_q >= 4'ha) else $error("select too soon");
    a_sclk_high: assert property (@(posedge clk_in) disable iff (rst_in)
        $rose(pins_q.sclk) |-> pins_q.sclk [*4]) else $error("sclk high too short");
    a_data_stable: assert property (@(posedge clk_in) disable iff (rst_in)
        pins_q.sclk |-> $stable(pins_q.serial_in_line)) else $error("data moved at high sclk");
    a_no_reset_sel: assert property (@(posedge clk_in) disable iff (rst_in)
        pins_q.reset |-> pins_q.sel_n) else $error("select during reset");
    a_done_pulse: assert property (@(posedge clk_in) disable iff (rst_in)
        $rose(pins_q.sel_n) |-> ##1 !done_q) else $error("done not single");
endmodule : scp_ctrl
`default_nettype wire

//--- rtl/scp_pkg.sv
`default_nettype none
package scp_pkg;
    // ***********************************************************
    // Frame layout on the serial link.
    // ***********************************************************
    localparam int unsigned FRAME_BITS   = 24;
    localparam int unsigned ADDR_BITS    = 8;
    localparam int unsigned DATA_BITS    = 16;
    localparam logic [7:0]  READOUT_ADDR = 8'h01;
    localparam int unsigned READOUT_BIT  = 0;
    localparam logic [7:0]  SWRST_ADDR   = 8'h00;
    localparam logic [15:0] SWRST_DATA   = 16'h0001;

    // ***********************************************************
    // Timing figures and their cycle counts at the system clock.
    // ***********************************************************
    localparam int unsigned CLK_PERIOD_NS   = 10;
    localparam int unsigned SCLK_MAX_MHZ    = 15;
    localparam int unsigned SCLK_MIN_NS     = (1000 + SCLK_MAX_MHZ - 1) / SCLK_MAX_MHZ;
    localparam int unsigned HALF_CYC        = (SCLK_MIN_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SETUP_NS        = 33;
    localparam int unsigned SETUP_CYC       = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RST_PULSE_NS    = 50;
    localparam int unsigned RST_PULSE_CYC   = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RST_WAIT_NS     = 100;
    localparam int unsigned RST_WAIT_CYC    = (RST_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ***********************************************************
    // Controller registers on APB (byte addresses).
    // ***********************************************************
    localparam logic [7:0]  REG_CTRL   = 8'h00;
    localparam logic [7:0]  REG_FRAME  = 8'h04;
    localparam logic [7:0]  REG_STATUS = 8'h08;
    localparam logic [7:0]  REG_RDATA  = 8'h0c;
    localparam int unsigned CTRL_GO    = 0;
    localparam int unsigned CTRL_READ  = 1;
    localparam int unsigned CTRL_HWRST = 2;
    localparam int unsigned STAT_BUSY  = 0;
    localparam int unsigned STAT_DONE  = 1;
    localparam int unsigned STAT_RDM   = 2;

    // Device pins as one group.
    typedef struct packed {
        logic sel_n;
        logic sclk;
        logic serial_in_line;
        logic reset;
    } scp_pins_t;

    // One command, held until the next write of the frame or control register.
    typedef struct packed {
        logic        hwrst;
        logic        read;
        logic [23:0] frame;
    } scp_cmd_t;
endpackage : scp_pkg
`default_nettype wire

//--- rtl/scp_sync.sv
`default_nettype none
// Two-flop synchroniser for a pin that comes from outside the clock domain.
module scp_sync (
    input  wire logic clk_in,  // System clock.
    input  wire logic rst_in,  // Asynchronous reset.
    input  wire logic d_in,    // Asynchronous level.
    output logic      q_out    // Synchronised level.
);
    logic meta_q;

    // First flop feeds only the second.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            meta_q <= 1'b0;
            q_out  <= 1'b0;
        end else begin
            meta_q <= d_in;
            q_out  <= meta_q;
        end
    end
endmodule : scp_sync
`default_nettype wire

//--- test/scp_ctrl_bench.sv
`default_nettype none
// Self-checking bench of the configuration port controller.
module scp_ctrl_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk_in = 0, rst_in = 1, psel = 0, penable = 0, pwrite = 0, tog = 0;
    logic [7:0]  paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic        pready, pslverr, sel_n, sclk, serial_in_line, dev_rst, rb, rb_oe_n;
    logic        rdm;
    logic [15:0] exp_regs [256];
    logic [7:0]  addr_q [$];
    int          viol, error_cnt = 0, samples_checked = 0, seed = 32'hdc3cb130;

    // Clock, and a changing level on the readback line while it floats.
    always #5 clk_in = ~clk_in;
    always @(posedge clk_in) tog <= ~tog;

    scp_ctrl scp_ctrl_inst (.clk_in(clk_in), .rst_in(rst_in), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sel_n_out(sel_n), .sclk_out(sclk), .serial_in_line_out(serial_in_line),
        .dev_reset_out(dev_rst), .serial_readback_line_in(rb_oe_n ? tog : rb));
    scp_dev_model scp_dev_model_inst (.sel_n_in(sel_n), .sclk_in(sclk), .serial_in_line_in(serial_in_line),
        .reset_in(dev_rst), .rb_out(rb), .rb_oe_n_out(rb_oe_n), .viol_out(viol));

    // ***********************************************************
    // Checking and bus tasks.
    // ***********************************************************
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wrap_up();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up

    // One APB transfer; the request stands until pready is seen high, for at most 100 cycles.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int   n;
        logic rdy;
        @(posedge clk_in);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        n = 0;
        do begin
            @(negedge clk_in);
            rdy = pready;
            r   = prdata;
            e   = pslverr;
            @(posedge clk_in);
            n++;
        end while (rdy !== 1'b1 && n < 100);
        if (n >= 100) error_cnt++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Sends one command, waits for done and updates the reference model.
    task automatic run(input logic [2:0] ctl, input logic [7:0] a, input logic [15:0] d);
        logic [31:0] r;
        logic        e;
        int          n;
        apb(1'b1, scp_pkg::REG_FRAME, {8'h00, a, d}, r, e);
        apb(1'b1, scp_pkg::REG_CTRL, {29'h0, ctl}, r, e);
        n = 0;
        r = '0;
        while (r[1] !== 1'b1 && n < 400) begin
            apb(1'b0, scp_pkg::REG_STATUS, '0, r, e);
            n++;
        end
        check("done flag", {31'h0, r[1]}, 32'h1);
        if (ctl[2] || (!rdm && a == 8'h00 && d[0])) foreach (exp_regs[i]) exp_regs[i] = '0;
        else if (!rdm || a == 8'h01) exp_regs[a] = d;
        rdm = exp_regs[1][0];
        apb(1'b0, scp_pkg::REG_STATUS, '0, r, e);
        check("status", r, {29'h0, rdm, 2'b00});
        check("device register", {16'h0, scp_dev_model_inst.regs[a]}, {16'h0, exp_regs[a]});
    endtask : run

    task automatic cmp_all();
        for (int i = 0; i < 256; i++)
            check("register image", {16'h0, scp_dev_model_inst.regs[i]}, {16'h0, exp_regs[i]});
    endtask : cmp_all

    task automatic rand_writes(input int k);
        logic [7:0] a;
        repeat (k) begin
            a = 8'($random(seed));
            if (a < 8'h02) a = a + 8'h02;
            addr_q.push_back(a);
            run(3'b001, a, 16'($random(seed)));
        end
    endtask : rand_writes

    // ***********************************************************
    // Main sequence.
    // ***********************************************************
    initial begin
        logic [31:0] r;
        logic        e;
        rdm = 1'b0;
        foreach (exp_regs[i]) exp_regs[i] = '0;
        repeat (4) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        check("idle pins", {28'h0, sel_n, sclk, serial_in_line, dev_rst}, 32'h8);
        rand_writes(6);
        run(3'b001, 8'h00, 16'h0001);
        cmp_all();
        rand_writes(4);
        run(3'b101, 8'h00, 16'h0000);
        cmp_all();
        addr_q.delete();
        rand_writes(5);
        run(3'b001, 8'h01, 16'h0001);
        run(3'b001, addr_q[0], ~exp_regs[addr_q[0]]);
        run(3'b001, 8'h00, 16'h0001);
        foreach (addr_q[i]) begin
            run(3'b011, addr_q[i], 16'h0000);
            apb(1'b0, scp_pkg::REG_RDATA, '0, r, e);
            check("readback word", r, {16'h0, exp_regs[addr_q[i]]});
        end
        run(3'b001, 8'h01, 16'h0000);
        run(3'b001, addr_q[1], 16'h5a5a);
        apb(1'b0, 8'h10, '0, r, e);
        check("unmapped access", {e, r[30:0]}, 32'h80000000);
        check("partner timing", 32'(viol), 32'h0);
        wrap_up();
    end

    // Watchdog against a hang.
    initial begin
        #500us;
        error_cnt++;
        wrap_up();
    end
endmodule : scp_ctrl_bench
`default_nettype wire

//--- test/scp_dev_model.sv
`default_nettype none
// Behavioural model of the configuration port of the converter.
module scp_dev_model #(
    parameter logic [15:0] DEF = 16'h0000  // Default of every register.
) (
    input  wire logic sel_n_in,    // Select, active low.
    input  wire logic sclk_in,     // Shift clock.
    input  wire logic serial_in_line_in,    // Serial input line.
    input  wire logic reset_in,    // Hardware reset, active high.
    output logic      rb_out,      // Readback bit.
    output logic      rb_oe_n_out, // Readback drive enable, active low.
    output int        viol_out     // Count of timing violations by the controller.
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] regs [256];
    logic [23:0] sh_q;
    logic [7:0]  rd_addr;
    int          cnt;
    realtime     t_rise, t_hi, t_lo;

    // Loads all defaults: normal mode, readback off.
    function automatic void load_def();
        foreach (regs[i]) regs[i] = DEF;
    endfunction : load_def

    // Power-up state.
    initial begin
        viol_out = 0;
        cnt = 0;
        rb_out = 1'b0;
        t_rise = -1000;
        t_lo = -1000;
        load_def();
    end
    // Hardware reset pulse loads defaults and its width is checked.
    always @(posedge reset_in) begin
        load_def();
        t_hi = $realtime;
    end
    always @(negedge reset_in) begin
        if ($realtime - t_hi < 50) viol_out++;
        t_lo = $realtime;
    end
    // Select must wait after reset release.
    always @(negedge sel_n_in) if ($realtime - t_lo < 100) viol_out++;
    // Releasing select drops a partial word.
    always @(posedge sel_n_in) cnt = 0;
    // Shifting and register loading at each 24th rising edge.
    always @(posedge sclk_in) begin
        if (!sel_n_in) begin
            if ($realtime - t_rise < 66.6) viol_out++;
            t_rise = $realtime;
            sh_q = {sh_q[22:0], serial_in_line_in};
            cnt++;
            if (cnt == 24) begin
                cnt = 0;
                if (regs[1][0] && sh_q[23:16] != 8'h01) begin
                    // Readback mode blocks the write.
                end else if (sh_q[23:16] == 8'h00 && sh_q[0]) begin
                    load_def();
                end else begin
                    regs[sh_q[23:16]] = sh_q[15:0];
                end
            end
        end
    end
    // Readback bits change on falling edges of the data part.
    always @(negedge sclk_in) begin
        if (!sel_n_in && regs[1][0] && cnt >= 8) begin
            if (cnt == 8) rd_addr = sh_q[7:0];
            rb_out = (rd_addr == 8'h01) ? 1'b0 : regs[rd_addr][23 - cnt];
        end
    end
    assign rb_oe_n_out = !regs[1][0];
endmodule : scp_dev_model
`default_nettype wire
